// ==== shared/omw_pkg.sv ====
// omw_pkg: register map, field positions, reset values, timing and types
// for the operating mode and wake-up controller.
// assumes an APB slave with 32-bit data, one word per register.
// Behaviour
// - clock select 111 in normal moves to slow
// - slow clock from chosen low osc, once stable
// - codes 000..110 in slow return to fast divided
// - halt with both keep bits low enters sleep
// - halt, fast 0 slow 1 enters sub-only standby
// - halt with both keep bits high, both clocks
// - halt, fast 1 slow 0 enters fast-only standby
// - power-down halts core, state retained
// - power-down sets pd flag, clears timeout flag
// - power-down clears watchdog count
// - wake on port edge, reset, interrupt, watchdog
// - reset wake full reset, watchdog wake watchdog reset
// - pd flag cleared by power-up or clear-watchdog
// - watchdog wake sets timeout, resets pc and sp
// - per-pin port wake enable, resume after halt
// - masked or stack-full interrupt resumes, stays pending
// - enabled interrupt with room takes interrupt response
// - interrupt flagged before entry cannot wake
// - resume only after system oscillator stable
// - clock select resets to 000, 111 sub clock
// - enabling fast osc clears stable then sets
package omw_pkg;
	localparam logic [7:0] OMW_ADDR_CLK = 8'h00;
	localparam logic [7:0] OMW_ADDR_OSC = 8'h04;
	localparam logic [7:0] OMW_ADDR_WAKE = 8'h08;
	localparam logic [7:0] OMW_ADDR_STAT = 8'h0C;
	// clock control word fields
	localparam int OMW_CKS_LSB = 5;
	localparam int OMW_FHS_BIT = 3;
	localparam int OMW_FSS_BIT = 2;
	localparam int OMW_FHID_BIT = 1;
	localparam int OMW_FSID_BIT = 0;
	localparam logic [7:0] OMW_CLK_RST = 8'h00;
	// oscillator control word fields
	localparam int OMW_HXT_EN_BIT = 0;
	localparam int OMW_HXT_F_BIT = 1;
	localparam int OMW_HRC_EN_BIT = 2;
	localparam int OMW_HRC_F_BIT = 3;
	localparam int OMW_LXT_EN_BIT = 4;
	localparam int OMW_LXT_F_BIT = 5;
	localparam int OMW_LRC_F_BIT = 6;
	localparam int OMW_WDT_EN_BIT = 7;
	localparam logic [7:0] OMW_OSC_RST = 8'h84;
	// status word fields
	localparam int OMW_PDF_BIT = 0;
	localparam int OMW_TO_BIT = 1;
	localparam int OMW_MODE_LSB = 4;
	localparam logic [2:0] OMW_CKS_SUB = 3'h7;
	localparam logic [7:0] OMW_WAKE_RST = 8'h00;
	// oscillator start-up figure and derived cycle count
	localparam int OMW_CLK_MHZ = 200;
	localparam int OMW_OSC_START_NS = 1000;
	localparam int OMW_OSC_START_CYC = (OMW_OSC_START_NS * OMW_CLK_MHZ + 999) / 1000;

	typedef enum logic [2:0] {
		OMW_NORMAL = 3'b000,
		OMW_SLOW = 3'b001,
		OMW_HALTED = 3'b011,
		OMW_WAKING = 3'b010
	} omw_state_t;

	typedef enum logic [1:0] {
		OMW_PD_SLEEP = 2'b00,
		OMW_PD_SUB = 2'b01,
		OMW_PD_BOTH = 2'b11,
		OMW_PD_FAST = 2'b10
	} omw_pd_t;

	typedef struct packed {
		logic fast_on;
		logic sub_on;
		logic cpu_on;
		logic [2:0] divide;
	} omw_clk_t;

	typedef struct packed {
		logic resume;
		logic take_irq;
		logic wdt_reset;
		logic full_reset;
	} omw_wake_t;
endpackage

// ==== rtl/omw_ctrl.sv ====
// omw_ctrl: operating mode switching, power-down entry and wake-up control.
// assumes core pulses halt and clear-watchdog for one cycle; oscillators and
// watchdog counter are outside; stability is reported as a level, overflow as a pulse.
//
// The register offsets and the APB register port are this design's own decisions.
module omw_ctrl #(
	parameter int PORT_W = 8,
	parameter int START_CYC = omw_pkg::OMW_OSC_START_CYC
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // async reset, high
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic halt_exec, // power-down instruction pulse
	input wire logic clr_wdt_exec, // clear-watchdog instruction pulse
	input wire logic ext_reset, // external reset request
	input wire logic wdt_overflow, // watchdog overflow pulse
	input wire logic irq_req, // interrupt request level
	input wire logic irq_enabled, // interrupt enabled
	input wire logic stack_full, // stack full
	input wire logic [PORT_W-1:0] porta_in, // port a pins
	input wire logic fast_osc_ready, // fast osc settled
	input wire logic slow_osc_ready, // slow osc settled
	output omw_pkg::omw_clk_t clk_ctrl, // clock gating and divide
	output omw_pkg::omw_wake_t wake_evt, // wake outcome pulses
	output logic core_stall, // core halted
	output logic wdt_clear, // watchdog count clear pulse
	output logic wdt_run // watchdog count enable
);
	omw_pkg::omw_state_t state_reg;
	omw_pkg::omw_pd_t pd_reg;
	logic [7:0] clk_reg, osc_reg, wake_en_reg;
	logic pdf_reg, to_reg, irq_block_reg, hxt_f_reg, hrc_f_reg;
	logic [PORT_W-1:0] porta_prev_reg;
	logic [$clog2(START_CYC+1)-1:0] start_cnt_reg;
	logic [2:0] cks;
	logic wr, rd_ok, port_fall, irq_wake, any_wake;
	logic [31:0] rdata_next;
	logic [7:0] status;

	assign cks = clk_reg[omw_pkg::OMW_CKS_LSB +: 3];
	assign wr = psel && penable && pwrite;
	assign rd_ok = (paddr == omw_pkg::OMW_ADDR_CLK) || (paddr == omw_pkg::OMW_ADDR_OSC) ||
		(paddr == omw_pkg::OMW_ADDR_WAKE) || (paddr == omw_pkg::OMW_ADDR_STAT);
	// pins sampled only to find edges; in a clockless sleep the pad cell latches this
	assign port_fall = |(porta_prev_reg & ~porta_in[PORT_W-1:0] & wake_en_reg[PORT_W-1:0]);
	assign irq_wake = irq_req && !irq_block_reg;
	assign any_wake = port_fall || ext_reset || wdt_overflow || irq_wake;
	assign status = {1'b0, state_reg, 2'b00, to_reg, pdf_reg};

	// apb slave, zero wait states
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !rd_ok;
			prdata <= rdata_next;
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (paddr)
			omw_pkg::OMW_ADDR_CLK: rdata_next[7:0] = clk_reg & 8'hEF;
			omw_pkg::OMW_ADDR_OSC: rdata_next[7:0] = {osc_reg[7], slow_osc_ready,
				osc_reg[5:4], hrc_f_reg, osc_reg[2], hxt_f_reg, osc_reg[0]};
			omw_pkg::OMW_ADDR_WAKE: rdata_next[7:0] = wake_en_reg;
			omw_pkg::OMW_ADDR_STAT: rdata_next[7:0] = status;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// software control words; accessed only in a two-phase transfer
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			clk_reg <= omw_pkg::OMW_CLK_RST;
			osc_reg <= omw_pkg::OMW_OSC_RST;
			wake_en_reg <= omw_pkg::OMW_WAKE_RST;
		end else if (wr && pready) begin
			unique case (paddr)
				omw_pkg::OMW_ADDR_CLK: clk_reg <= pwdata[7:0] & 8'hEF;
				omw_pkg::OMW_ADDR_OSC: osc_reg <= pwdata[7:0];
				omw_pkg::OMW_ADDR_WAKE: wake_en_reg <= pwdata[7:0];
				default: clk_reg <= clk_reg;
			endcase
		end
	end

	// fast osc stable flags: cleared on enable, set once settled
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hxt_f_reg <= 1'b0;
			hrc_f_reg <= 1'b0;
		end else begin
			if (wr && pready && paddr == omw_pkg::OMW_ADDR_OSC &&
				pwdata[omw_pkg::OMW_HXT_EN_BIT] && !osc_reg[omw_pkg::OMW_HXT_EN_BIT])
				hxt_f_reg <= 1'b0;
			else
				hxt_f_reg <= osc_reg[omw_pkg::OMW_HXT_EN_BIT] && fast_osc_ready;
			if (wr && pready && paddr == omw_pkg::OMW_ADDR_OSC &&
				pwdata[omw_pkg::OMW_HRC_EN_BIT] && !osc_reg[omw_pkg::OMW_HRC_EN_BIT])
				hrc_f_reg <= 1'b0;
			else
				hrc_f_reg <= osc_reg[omw_pkg::OMW_HRC_EN_BIT] && fast_osc_ready;
		end
	end

	// operating mode sequencer
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= omw_pkg::OMW_NORMAL;
			pd_reg <= omw_pkg::OMW_PD_SLEEP;
			start_cnt_reg <= '0;
		end else begin
			unique case (state_reg)
				omw_pkg::OMW_NORMAL: begin
					if (halt_exec) begin
						state_reg <= omw_pkg::OMW_HALTED;
						pd_reg <= omw_pkg::omw_pd_t'({clk_reg[omw_pkg::OMW_FHID_BIT],
							clk_reg[omw_pkg::OMW_FSID_BIT]});
					end else if (cks == omw_pkg::OMW_CKS_SUB && slow_osc_ready)
						state_reg <= omw_pkg::OMW_SLOW;
				end
				omw_pkg::OMW_SLOW: begin
					if (halt_exec) begin
						state_reg <= omw_pkg::OMW_HALTED;
						pd_reg <= omw_pkg::omw_pd_t'({clk_reg[omw_pkg::OMW_FHID_BIT],
							clk_reg[omw_pkg::OMW_FSID_BIT]});
					end else if (cks != omw_pkg::OMW_CKS_SUB && fast_osc_ready)
						state_reg <= omw_pkg::OMW_NORMAL;
				end
				omw_pkg::OMW_HALTED: begin
					start_cnt_reg <= '0;
					if (any_wake && !ext_reset && !wdt_overflow)
						state_reg <= omw_pkg::OMW_WAKING;
					else if (ext_reset || wdt_overflow)
						state_reg <= omw_pkg::OMW_NORMAL;
				end
				omw_pkg::OMW_WAKING: begin
					if (start_cnt_reg < START_CYC[$bits(start_cnt_reg)-1:0])
						start_cnt_reg <= start_cnt_reg + 1'b1;
					else if (cks == omw_pkg::OMW_CKS_SUB ? slow_osc_ready : fast_osc_ready)
						state_reg <= (cks == omw_pkg::OMW_CKS_SUB) ?
							omw_pkg::OMW_SLOW : omw_pkg::OMW_NORMAL;
				end
				default: state_reg <= omw_pkg::OMW_NORMAL;
			endcase
		end
	end

	// interrupt already pending at entry cannot wake
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			irq_block_reg <= 1'b0;
		else if (halt_exec && state_reg != omw_pkg::OMW_HALTED)
			irq_block_reg <= irq_req;
		else if (!irq_req)
			irq_block_reg <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			porta_prev_reg <= '0;
		else
			porta_prev_reg <= porta_in;
	end

	// status flags; timeout set wins over a same-cycle clear
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pdf_reg <= 1'b0;
			to_reg <= 1'b0;
		end else begin
			if (halt_exec && state_reg != omw_pkg::OMW_HALTED)
				pdf_reg <= 1'b1;
			else if (clr_wdt_exec)
				pdf_reg <= 1'b0;
			if (state_reg == omw_pkg::OMW_HALTED && wdt_overflow)
				to_reg <= 1'b1;
			else if (halt_exec && state_reg != omw_pkg::OMW_HALTED)
				to_reg <= 1'b0;
		end
	end

	// outputs, all registered
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			clk_ctrl <= '{fast_on: 1'b1, sub_on: 1'b1, cpu_on: 1'b1, divide: 3'h0};
			wake_evt <= '0;
			core_stall <= 1'b0;
			wdt_clear <= 1'b0;
			wdt_run <= 1'b1;
		end else begin
			wdt_clear <= (halt_exec && state_reg != omw_pkg::OMW_HALTED) ||
				clr_wdt_exec;
			wdt_run <= osc_reg[omw_pkg::OMW_WDT_EN_BIT];
			core_stall <= (state_reg == omw_pkg::OMW_HALTED) ||
				(state_reg == omw_pkg::OMW_WAKING) || halt_exec;
			clk_ctrl.cpu_on <= !(state_reg == omw_pkg::OMW_HALTED ||
				state_reg == omw_pkg::OMW_WAKING);
			clk_ctrl.divide <= cks;
			if (state_reg == omw_pkg::OMW_HALTED) begin
				clk_ctrl.fast_on <= pd_reg[1];
				clk_ctrl.sub_on <= pd_reg[0];
			end else begin
				// fast clock may be dropped by software only in slow mode
				clk_ctrl.fast_on <= (state_reg != omw_pkg::OMW_SLOW) ||
					osc_reg[omw_pkg::OMW_HXT_EN_BIT] || osc_reg[omw_pkg::OMW_HRC_EN_BIT];
				clk_ctrl.sub_on <= 1'b1;
			end
			wake_evt.full_reset <= state_reg == omw_pkg::OMW_HALTED && ext_reset;
			wake_evt.wdt_reset <= state_reg == omw_pkg::OMW_HALTED && !ext_reset &&
				wdt_overflow;
			wake_evt.resume <= 1'b0;
			wake_evt.take_irq <= 1'b0;
			if (state_reg == omw_pkg::OMW_WAKING && start_cnt_reg >=
				START_CYC[$bits(start_cnt_reg)-1:0] &&
				(cks == omw_pkg::OMW_CKS_SUB ? slow_osc_ready : fast_osc_ready)) begin
				wake_evt.take_irq <= irq_req && irq_enabled && !stack_full;
				wake_evt.resume <= !(irq_req && irq_enabled && !stack_full);
			end
		end
	end
endmodule

// ==== tb/omw_osc_model.sv ====
// omw_osc_model: oscillators beside the controller, settle after enable.
// assumes clk_ctrl enables are registered levels.
module omw_osc_model #(
	parameter int SETTLE = 3
) (
	input wire logic clk_sys, // clock
	input wire omw_pkg::omw_clk_t clk_ctrl, // oscillator enables
	output logic fast_osc_ready, // fast settled
	output logic slow_osc_ready // slow settled
);
	timeunit 1ns;
	timeprecision 1ps;
	int fast_cnt = 0;
	int slow_cnt = 0;
	always_ff @(posedge clk_sys) begin
		fast_cnt <= clk_ctrl.fast_on ? fast_cnt + 1 : 0;
		slow_cnt <= clk_ctrl.sub_on ? slow_cnt + 1 : 0;
	end
	assign fast_osc_ready = fast_cnt >= SETTLE;
	assign slow_osc_ready = slow_cnt >= SETTLE;
endmodule

// ==== tb/omw_ctrl_monitor.sv ====
// omw_ctrl_monitor: port assertions for omw_ctrl, bound below.
// assumes one-cycle apb answer and registered wake pulses.
module omw_ctrl_monitor #(
	parameter int START_CYC = 4
) (
	input wire logic clk_sys, // clock
	input wire logic sys_rst, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic halt_exec, // halt pulse
	input wire logic ext_reset, // external reset
	input wire logic wdt_overflow, // overflow
	input wire omw_pkg::omw_clk_t clk_ctrl, // clocks
	input wire omw_pkg::omw_wake_t wake_evt, // wake pulses
	input wire logic core_stall, // halted
	input wire logic wdt_clear // count clear
);
	int stall_cnt;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			stall_cnt <= 0;
		else if (!core_stall)
			stall_cnt <= 0;
		else if (stall_cnt < 1000)
			stall_cnt <= stall_cnt + 1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_halt; halt_exec && !core_stall; endsequence
	sequence s_setup; psel && !penable; endsequence
	property p_halt_stall; s_halt |=> core_stall && wdt_clear; endproperty
	a_halt_stall: assert property (p_halt_stall) else $error("halt not taken");
	property p_cpu_off; s_halt |-> ##2 !clk_ctrl.cpu_on; endproperty
	a_cpu_off: assert property (p_cpu_off) else $error("cpu clock kept");
	property p_ready; s_setup |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_ext;
		core_stall && ext_reset && !wake_evt.full_reset |-> ##[1:3] wake_evt.full_reset;
	endproperty
	a_ext: assert property (p_ext) else $error("no full reset");
	property p_wdt; core_stall && wdt_overflow |-> ##[1:3] wake_evt.wdt_reset; endproperty
	a_wdt: assert property (p_wdt) else $error("no wdt reset");
	property p_wait; wake_evt.resume |-> stall_cnt >= START_CYC; endproperty
	a_wait: assert property (p_wait) else $error("resumed early");
	property p_run; wake_evt.resume |-> ##[0:1] !core_stall; endproperty
	a_run: assert property (p_run) else $error("still stalled");
	property p_irq; wake_evt.take_irq |=> !wake_evt.take_irq; endproperty
	a_irq: assert property (p_irq) else $error("irq pulse long");
endmodule
bind omw_ctrl omw_ctrl_monitor #(.START_CYC(START_CYC)) omw_ctrl_monitor_i (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .halt_exec(halt_exec), .ext_reset(ext_reset),
	.wdt_overflow(wdt_overflow), .clk_ctrl(clk_ctrl), .wake_evt(wake_evt),
	.core_stall(core_stall), .wdt_clear(wdt_clear));

// ==== tb/tb_omw_ctrl.sv ====
// tb_omw_ctrl: self-checking bench for omw_ctrl.
// assumes omw_osc_model as oscillators and the bound checker.
module tb_omw_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, halt_exec = 0;
	logic clr_wdt_exec = 0, ext_reset = 0, wdt_overflow = 0, irq_req = 0, irq_enabled = 0;
	logic stack_full = 0, pready, pslverr, core_stall, wdt_clear, wdt_run, fast_rdy, slow_rdy;
	logic [7:0] paddr = '0, porta_in = 8'hff;
	logic [31:0] pwdata = '0, prdata;
	omw_pkg::omw_clk_t clk_ctrl;
	omw_pkg::omw_wake_t wake_evt;
	logic [64:0] exp_q[$];
	integer seed = 32'h0000_32b2;
	int mismatches = 0, n_compared = 0;
	omw_ctrl #(.START_CYC(4)) omw_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec),
		.ext_reset(ext_reset), .wdt_overflow(wdt_overflow), .irq_req(irq_req),
		.irq_enabled(irq_enabled), .stack_full(stack_full), .porta_in(porta_in),
		.fast_osc_ready(fast_rdy), .slow_osc_ready(slow_rdy), .clk_ctrl(clk_ctrl),
		.wake_evt(wake_evt), .core_stall(core_stall), .wdt_clear(wdt_clear), .wdt_run(wdt_run));
	omw_osc_model omw_osc_model_i (.clk_sys(clk_sys), .clk_ctrl(clk_ctrl),
		.fast_osc_ready(fast_rdy), .slow_osc_ready(slow_rdy));
	initial forever #2.5 clk_sys = ~clk_sys;
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// read data and error come back through the queue
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic e);
		if (!w)
			exp_q.push_back({e, m, d});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so a following call never re-drives psel in this step
		@(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		logic [64:0] e;
		if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() != 0) begin
			e = exp_q.pop_front();
			check({31'h0, pslverr}, {31'h0, e[64]});
			check(prdata & e[63:32], e[31:0]);
		end
	end
	task automatic wait_evt(input int b);
		int t;
		t = 0;
		while (wake_evt[b] !== 1'b1 && t < 500) begin
			@(posedge clk_sys);
			t++;
		end
		check({31'h0, wake_evt[b]}, 32'h0000_0001);
	endtask
	task automatic pulse_halt;
		halt_exec <= 1'b1;
		@(posedge clk_sys);
		halt_exec <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	initial begin
		#100us;
		mismatches++;
		results();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		check({31'h0, wdt_run}, 32'h0000_0001);
		apb(0, omw_pkg::OMW_ADDR_CLK, '0, '1, 0);
		apb(0, omw_pkg::OMW_ADDR_STAT, '0, '1, 0);
		apb(0, 8'h10, '0, '1, 1);
		for (int c = 0; c < 7; c++) begin
			apb(1, omw_pkg::OMW_ADDR_CLK, 32'h0000_00e0, '0, 0);
			repeat (20) @(posedge clk_sys);
			apb(0, omw_pkg::OMW_ADDR_STAT, 32'h0000_0010, 32'h0000_0070, 0);
			apb(1, omw_pkg::OMW_ADDR_CLK, 32'(c) << 5, '0, 0);
			repeat (20) @(posedge clk_sys);
			check({29'h0, clk_ctrl.divide}, 32'(c));
			apb(0, omw_pkg::OMW_ADDR_STAT, '0, 32'h0000_0070, 0);
		end
		for (int k = 0; k < 4; k++) begin
			apb(1, omw_pkg::OMW_ADDR_WAKE, 32'($random(seed)) & 32'h0000_00ff | 32'h1, '0, 0);
			apb(1, omw_pkg::OMW_ADDR_CLK, 32'(k), '0, 0);
			pulse_halt();
			check({core_stall, clk_ctrl.fast_on, clk_ctrl.sub_on, clk_ctrl.cpu_on},
				{1'b1, k[1], k[0], 1'b0});
			apb(0, omw_pkg::OMW_ADDR_STAT, 32'h0000_0031, 32'h0000_0073, 0);
			porta_in <= (k == 0) ? 8'hfe : 8'hff;
			irq_req <= k == 1 || k == 2;
			irq_enabled <= k == 1;
			stack_full <= k == 2;
			wdt_overflow <= k == 3;
			@(posedge clk_sys);
			wdt_overflow <= 1'b0;
			wait_evt((k == 3) ? 1 : (k == 1) ? 2 : 3);
			porta_in <= 8'hff;
			irq_req <= 1'b0;
			repeat (10) @(posedge clk_sys);
			apb(0, omw_pkg::OMW_ADDR_STAT, (k == 3) ? 3 : 1, 32'h0000_0073, 0);
		end
		clr_wdt_exec <= 1'b1;
		@(posedge clk_sys);
		clr_wdt_exec <= 1'b0;
		apb(0, omw_pkg::OMW_ADDR_STAT, '0, 32'h0000_0001, 0);
		irq_req <= 1'b1;
		irq_enabled <= 1'b1;
		apb(1, omw_pkg::OMW_ADDR_CLK, '0, '0, 0);
		pulse_halt();
		repeat (30) @(posedge clk_sys);
		check({31'h0, core_stall}, 32'h0000_0001);
		ext_reset <= 1'b1;
		wait_evt(0);
		ext_reset <= 1'b0;
		repeat (20) @(posedge clk_sys);
		results();
	end
endmodule
